// ==== design/scan_seq_pkg.sv ====
// Purpose: shared constants for the channel scan sequencer
// Assumes: AHB-Lite word registers, 20 MHz core clock
// Notes: offsets are byte addresses
package scan_seq_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LIST_LEN = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_STATE = 8'h0c;
  localparam logic [7:0] OFF_OPER = 8'h10;
  localparam logic [7:0] OFF_OPER_EN = 8'h14;
  localparam logic [7:0] OFF_STB = 8'h18;
  localparam logic [7:0] OFF_SRE = 8'h1c;
  localparam logic [7:0] OFF_INT_MASK = 8'h20;
  localparam logic [7:0] OFF_LIST_BASE = 8'h40;
  // ctrl fields
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_ANALOG_BUS_ROUTE_BIT = 4;
  localparam int CTRL_DL_BIT = 5;
  localparam int CTRL_ARM_LSB = 8;
  // command bits
  localparam int CMD_INIT_BIT = 0;
  localparam int CMD_TRIG_BIT = 1;
  localparam int CMD_CLS_BIT = 2;
  localparam int CMD_ABORT_BIT = 3;
  localparam int OPER_SCAN_BIT = 8;
  localparam int STB_OPER_BIT = 7;
  localparam int STB_SRQ_BIT = 6;
  localparam logic [2:0] SRC_IMM = 3'h0;
  localparam logic [2:0] SRC_BUS = 3'h1;
  localparam logic [2:0] SRC_HOLD = 3'h2;
  localparam logic [2:0] SRC_EXT = 3'h3;
  localparam logic [2:0] SRC_HANDSHAKE = 3'h4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0102;
  // timing: settling and strobe width
  localparam int CLK_HZ = 20_000_000;
  localparam int SETTLE_NS = 500;
  localparam int STROBE_NS = 200;
  localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int STROBE_CYC = (STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  typedef enum logic [2:0] {ST_IDLE, ST_SETTLE, ST_STROBE, ST_WAIT, ST_DONE} seq_state_t;
endpackage

// ==== design/scan_handshake_sequencer.sv ====
// Purpose: channel scan sequencer paced by handshake or trigger sources
// Assumes: single core clock, synchronous active low reset
// Notes: registers on AHB-Lite, zero wait states
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - handshake source advances only from stepNext
// - initiate closes first list channel
// - in handshake mode, pulse channelDone after each closure
// - stepNext opens current, closes next
// - repeat per entry, stop after last
// - completion sets operation status bit 8
// - all other operation bits read zero
// - operation status readable at own address
// - enabled bit 8 summarizes into STB bit7
// - status byte readable by poll, query
// - SRE bit 128 raises service request
// - clear-status clears the operation event flag; enables keep their values
// - external source advances from extEvent
// - analog bus route drives bus and tree
// - arm count ignored for downloaded lists
// - immediate trigger advances in bus/hold
module scan_handshake_sequencer
  import scan_seq_pkg::*;
#(
  parameter int LIST_DEPTH = 16
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic stepNext,
  input wire logic extEvent,
  output logic channelDone,
  output logic [15:0] channelClose,
  output logic analogBusRoute,
  output logic treeARoute,
  output logic serviceRequest,
  output logic irq
);
  // elaboration guard: the list store and index are sized for sixteen entries
  if (LIST_DEPTH < 2 || LIST_DEPTH > 16)
  begin : g_depth_check
    $error("LIST_DEPTH must be 2..16");
  end

  typedef struct packed {
    logic [31:0] ctrl;
    logic [4:0] listLen;
    logic [15:0][3:0] list;
    logic [3:0] idx;
    logic [7:0] armLeft;
    seq_state_t st;
    logic [7:0] cnt;
    logic advPending;
    logic operEvt;
    logic operEn;
    logic sreEn;
    logic intMask;
    logic [2:0] stepSync;
    logic [2:0] extSync;
    logic stepLvl;
    logic extLvl;
    logic apPend;
    logic apWrite;
    logic [7:0] apAddr;
    logic [31:0] hrdata;
    logic channelDone;
    logic [15:0] channelClose;
    logic analog_bus_route;
    logic tree;
    logic srq;
    logic irq;
  } state_t;
  state_t cur, nxt;

  function automatic logic [15:0] onehot(input logic [3:0] ch);
    onehot = 16'h0001 << ch;
  endfunction

  logic stepRise, extRise, stbBit;
  // a change counts once the 2nd and 3rd synchroniser stages agree
  assign stepRise = cur.stepSync[2] & cur.stepSync[1] & ~cur.stepLvl;
  assign extRise = cur.extSync[2] & cur.extSync[1] & ~cur.extLvl;
  assign stbBit = cur.operEvt & cur.operEn;

  logic busReq, readOper, initReq, abortReq, evtSet;
  // whole-word transfers only; other sizes are ignored rather than half-written
  assign busReq = hsel & htrans[1] & hready & (hsize == 3'h2);
  assign readOper = busReq & ~hwrite & (haddr[7:0] == OFF_OPER);
  // command strobes seen in the data phase, also watched by the assertions
  assign initReq = cur.apPend & cur.apWrite & (cur.apAddr == OFF_CMD) & hwdata[CMD_INIT_BIT];
  assign abortReq = cur.apPend & cur.apWrite & (cur.apAddr == OFF_CMD) & hwdata[CMD_ABORT_BIT];

  always_comb
  begin
    logic adv;
    logic doInit, doTrig, doCls, doAbort;
    logic [2:0] src;
    adv = 1'b0;
    doInit = 1'b0;
    doTrig = 1'b0;
    doCls = 1'b0;
    doAbort = 1'b0;
    evtSet = 1'b0;
    nxt = cur;
    src = cur.ctrl[CTRL_SRC_LSB +: 3];
    nxt.stepSync = {cur.stepSync[1:0], stepNext};
    nxt.extSync = {cur.extSync[1:0], extEvent};
    if (cur.stepSync[2] == cur.stepSync[1])
      nxt.stepLvl = cur.stepSync[2];
    if (cur.extSync[2] == cur.extSync[1])
      nxt.extLvl = cur.extSync[2];
    nxt.channelDone = 1'b0;
    // address phase capture, data phase completes next cycle
    nxt.apPend = busReq;
    nxt.apWrite = hwrite;
    nxt.apAddr = haddr[7:0];
    if (cur.apPend && cur.apWrite)
    begin
      unique case (cur.apAddr)
        OFF_CTRL: nxt.ctrl = hwdata;
        OFF_LIST_LEN: nxt.listLen = hwdata[4:0];
        OFF_CMD:
        begin
          doInit = hwdata[CMD_INIT_BIT];
          doTrig = hwdata[CMD_TRIG_BIT];
          doCls = hwdata[CMD_CLS_BIT];
          doAbort = hwdata[CMD_ABORT_BIT];
        end
        OFF_OPER_EN: nxt.operEn = hwdata[OPER_SCAN_BIT];
        OFF_SRE: nxt.sreEn = hwdata[STB_OPER_BIT];
        OFF_INT_MASK: nxt.intMask = hwdata[OPER_SCAN_BIT];
        default:
          if (cur.apAddr >= OFF_LIST_BASE && cur.apAddr < OFF_LIST_BASE + 8'h40
              && int'(cur.apAddr[5:2]) < LIST_DEPTH)
            nxt.list[cur.apAddr[5:2]] = hwdata[3:0];
      endcase
    end
    // read data is registered; reading the operation register clears it
    nxt.hrdata = 32'h0;
    if (busReq && !hwrite)
    begin
      unique case (haddr[7:0])
        OFF_CTRL: nxt.hrdata = cur.ctrl;
        OFF_LIST_LEN: nxt.hrdata = {27'h0, cur.listLen};
        OFF_STATE: nxt.hrdata = {20'h0, cur.idx, 5'h0, cur.st};
        OFF_OPER:
        begin
          nxt.hrdata = 32'h0;
          nxt.hrdata[OPER_SCAN_BIT] = cur.operEvt;
        end
        OFF_OPER_EN: nxt.hrdata = {23'h0, cur.operEn, 8'h0};
        OFF_STB: nxt.hrdata = {24'h0, stbBit, cur.srq, 6'h0};
        OFF_SRE: nxt.hrdata = {24'h0, cur.sreEn, 7'h0};
        OFF_INT_MASK: nxt.hrdata = {23'h0, cur.intMask, 8'h0};
        default:
          if (haddr[7:0] >= OFF_LIST_BASE)
            nxt.hrdata = {28'h0, cur.list[haddr[5:2]]};
      endcase
    end
    // pick advance source
    unique case (src)
      SRC_HANDSHAKE: adv = stepRise;
      SRC_EXT: adv = extRise;
      SRC_BUS, SRC_HOLD: adv = doTrig;
      default: adv = 1'b1;
    endcase
    if (adv && cur.st != ST_IDLE && cur.st != ST_DONE)
      nxt.advPending = 1'b1; // held until settle and strobe are over
    unique case (cur.st)
      ST_IDLE, ST_DONE:
        if (doInit && cur.listLen != 5'h0)
        begin
          nxt.idx = 4'h0;
          nxt.channelClose = onehot(cur.list[0]);
          nxt.analog_bus_route = cur.ctrl[CTRL_ANALOG_BUS_ROUTE_BIT];
          nxt.tree = cur.ctrl[CTRL_ANALOG_BUS_ROUTE_BIT];
          nxt.armLeft = cur.ctrl[CTRL_DL_BIT] ? 8'h1 : cur.ctrl[CTRL_ARM_LSB +: 8];
          nxt.advPending = 1'b0;
          nxt.cnt = 8'(SETTLE_CYC);
          nxt.st = ST_SETTLE;
        end
      ST_SETTLE:
        if (cur.cnt == 8'h1)
        begin
          nxt.cnt = 8'(STROBE_CYC);
          nxt.st = ST_STROBE;
          nxt.channelDone = (src == SRC_HANDSHAKE);
        end
        else
          nxt.cnt = cur.cnt - 8'h1;
      ST_STROBE:
        if (cur.cnt == 8'h1)
          nxt.st = ST_WAIT;
        else
        begin
          nxt.cnt = cur.cnt - 8'h1;
          nxt.channelDone = (src == SRC_HANDSHAKE);
        end
      ST_WAIT:
        if (cur.advPending || adv)
        begin
          nxt.advPending = 1'b0;
          nxt.cnt = 8'(SETTLE_CYC);
          if ({1'b0, cur.idx} + 5'h1 < cur.listLen)
          begin
            nxt.idx = cur.idx + 4'h1;
            nxt.channelClose = onehot(cur.list[cur.idx + 4'h1]);
            nxt.st = ST_SETTLE;
          end
          else if (cur.armLeft > 8'h1)
          begin
            nxt.armLeft = cur.armLeft - 8'h1;
            nxt.idx = 4'h0;
            nxt.channelClose = onehot(cur.list[0]);
            nxt.st = ST_SETTLE;
          end
          else
          begin
            nxt.channelClose = 16'h0;
            nxt.st = ST_DONE;
            nxt.operEvt = 1'b1;
            evtSet = 1'b1;
          end
        end
    endcase
    if (doAbort)
    begin
      nxt.st = ST_IDLE;
      nxt.channelClose = 16'h0;
    end
    // read-clear and clear-status both lose to a completion in the same cycle,
    // so a scan that ends during a poll is never lost
    if (readOper && !evtSet)
      nxt.operEvt = 1'b0;
    if (doCls && !evtSet)
      nxt.operEvt = 1'b0;
    // levels follow the new flag and masks, so they settle together with the flag
    nxt.srq = nxt.operEvt & nxt.operEn & nxt.sreEn;
    nxt.irq = nxt.operEvt & nxt.intMask;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cur <= '0;
      cur.ctrl <= CTRL_RESET;
      cur.st <= ST_IDLE;
    end
    else
      cur <= nxt;
  end

  assign hrdata = cur.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign channelDone = cur.channelDone;
  assign channelClose = cur.channelClose;
  assign analogBusRoute = cur.analog_bus_route;
  assign treeARoute = cur.tree;
  assign serviceRequest = cur.srq;
  assign irq = cur.irq;

  property p_done_sets_flag;
    @(posedge core_clk) disable iff (!rst_n)
      (cur.st == ST_WAIT && nxt.st == ST_DONE) |=> cur.operEvt;
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag)
    else $error("scan completion did not set flag");

  property p_strobe_width;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(channelDone) |-> channelDone[*4] ##1 !channelDone;
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("channel done width wrong");

  property p_strobe_only_handshake;
    @(posedge core_clk) disable iff (!rst_n)
      channelDone |-> cur.ctrl[2:0] == SRC_HANDSHAKE;
  endproperty
  a_strobe_only_handshake: assert property (p_strobe_only_handshake)
    else $error("strobe outside handshake mode");

  property p_one_channel;
    @(posedge core_clk) disable iff (!rst_n)
      $onehot0(channelClose);
  endproperty
  a_one_channel: assert property (p_one_channel)
    else $error("more than one channel closed");

  property p_srq_follows;
    @(posedge core_clk) disable iff (!rst_n)
      (cur.operEvt && cur.operEn && cur.sreEn) |-> serviceRequest;
  endproperty
  a_srq_follows: assert property (p_srq_follows)
    else $error("service request missing");

  property p_cls_clears;
    @(posedge core_clk) disable iff (!rst_n)
      (cur.apPend && cur.apWrite && cur.apAddr == OFF_CMD && hwdata[CMD_CLS_BIT] && !evtSet)
        |=> !cur.operEvt;
  endproperty
  a_cls_clears: assert property (p_cls_clears)
    else $error("clear status left flag set");

  property p_route_pair;
    @(posedge core_clk) disable iff (!rst_n)
      analogBusRoute == treeARoute;
  endproperty
  a_route_pair: assert property (p_route_pair)
    else $error("analog bus and tree differ");

  property p_no_adv_settle;
    @(posedge core_clk) disable iff (!rst_n)
      (cur.st == ST_SETTLE && !abortReq) |=> $stable(channelClose);
  endproperty
  a_no_adv_settle: assert property (p_no_adv_settle)
    else $error("channel changed while settling");

  property p_srq_needs_event;
    @(posedge core_clk) disable iff (!rst_n)
      serviceRequest |-> (cur.operEvt && cur.operEn && cur.sreEn);
  endproperty
  a_srq_needs_event: assert property (p_srq_needs_event)
    else $error("service request without enabled event");

  property p_irq_needs_event;
    @(posedge core_clk) disable iff (!rst_n)
      irq |-> (cur.operEvt && cur.intMask);
  endproperty
  a_irq_needs_event: assert property (p_irq_needs_event)
    else $error("interrupt without unmasked event");

  property p_read_clears;
    @(posedge core_clk) disable iff (!rst_n)
      (readOper && !evtSet) |=> !cur.operEvt;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("operation status read left flag set");

  property p_oper_bits;
    @(posedge core_clk) disable iff (!rst_n)
      (cur.apPend && !cur.apWrite && cur.apAddr == OFF_OPER)
        |-> (hrdata[31:9] == 23'h0 && hrdata[7:0] == 8'h00);
  endproperty
  a_oper_bits: assert property (p_oper_bits)
    else $error("operation status shows a bit other than scan complete");

  property p_stb_summary;
    @(posedge core_clk) disable iff (!rst_n)
      (cur.apPend && !cur.apWrite && cur.apAddr == OFF_STB)
        |-> hrdata[STB_OPER_BIT] == $past(cur.operEvt && cur.operEn);
  endproperty
  a_stb_summary: assert property (p_stb_summary)
    else $error("status byte summary bit wrong");

  property p_first_channel;
    @(posedge core_clk) disable iff (!rst_n)
      (initReq && !abortReq && cur.listLen != 5'h0 && (cur.st == ST_IDLE || cur.st == ST_DONE))
        |=> channelClose == onehot(cur.list[0]);
  endproperty
  a_first_channel: assert property (p_first_channel)
    else $error("initiate did not close the first list channel");

  property p_handshake_only;
    @(posedge core_clk) disable iff (!rst_n)
      (cur.st == ST_WAIT && cur.ctrl[2:0] == SRC_HANDSHAKE && !cur.advPending && !stepRise
        && !abortReq) |=> cur.st == ST_WAIT;
  endproperty
  a_handshake_only: assert property (p_handshake_only)
    else $error("handshake scan advanced without step input");
endmodule // scan_handshake_sequencer
`default_nettype wire

// ==== bench/meter_model.sv ====
// Purpose: measuring partner on the handshake lines of the sequencer
// Assumes: stepNext idles low and is pulsed high by the meter
// Notes: eager mode pulses during settling, only when the bench asks
`timescale 1ns/1ps
`default_nettype none
module meter_model (
  input wire logic core_clk,
  input wire logic channelDone,
  input wire logic [15:0] channelClose,
  input wire logic eager,
  input wire logic [7:0] lag,
  output logic stepNext
);
  logic [15:0] seen;
  // one reading per strobe, then an advance pulse
  initial
  begin
    stepNext = 1'b0;
    seen = 16'h0000;
    forever
    begin
      @(posedge core_clk);
      if (eager ? (channelClose != 16'h0000 && channelClose != seen) : channelDone)
      begin
        seen = channelClose;
        repeat (lag) @(posedge core_clk);
        stepNext <= 1'b1;
        repeat (4) @(posedge core_clk);
        stepNext <= 1'b0;
        // never answer one strobe twice
        while (channelDone)
          @(posedge core_clk);
      end
    end
  end
endmodule // meter_model
`default_nettype wire

// ==== bench/scan_handshake_sequencer_test.sv ====
// Purpose: self-checking bench for the scan sequencer
// Assumes: zero wait AHB slave, meter model on the handshake lines
// Notes: register table first, then at least one scan per trigger source
`timescale 1ns/1ps
`default_nettype none
module scan_handshake_sequencer_test;
  import scan_seq_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic extEvent = 1'b0;
  logic eager = 1'b0;
  logic [7:0] lag = 8'h28;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, stepNext, channelDone, analogBusRoute, treeARoute;
  logic serviceRequest, irq;
  logic [15:0] channelClose;
  logic [15:0] prevClose = 16'h0000;
  logic [15:0] closeLog[$], doneLog[$];
  logic [3:0] chan[3] = '{4'h5, 4'h9, 4'hf};
  int errors = 0, checks_done = 0, width = 0;
  int widths[$];
  // plain writes then reads, last row unmapped
  row_t rows[6] = '{'{OFF_CTRL, 32'h0000_0514, 32'h0000_0514},
    '{OFF_OPER_EN, 32'h0000_0100, 32'h0000_0100}, '{OFF_SRE, 32'h0000_0080, 32'h0000_0080},
    '{OFF_INT_MASK, 32'h0000_0100, 32'h0000_0100}, '{OFF_LIST_LEN, 32'h0000_0003, 32'h0000_0003},
    '{8'h3c, 32'hffff_ffff, 32'h0000_0000}};

  // 20 MHz core clock
  initial
    forever #25 core_clk = ~core_clk;

  scan_handshake_sequencer scan_handshake_sequencer_inst (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .stepNext(stepNext), .extEvent(extEvent),
    .channelDone(channelDone), .channelClose(channelClose), .analogBusRoute(analogBusRoute),
    .treeARoute(treeARoute), .serviceRequest(serviceRequest), .irq(irq));

  meter_model meter_model_inst (.core_clk(core_clk), .channelDone(channelDone),
    .channelClose(channelClose), .eager(eager), .lag(lag), .stepNext(stepNext));

  // logs every closure, every strobe with its channel, and strobe widths
  always @(posedge core_clk)
  begin
    if (channelClose != prevClose && channelClose != 16'h0000) closeLog.push_back(channelClose);
    prevClose <= channelClose;
    if (channelDone)
    begin
      if (width == 0) doneLog.push_back(channelClose);
      width <= width + 1;
    end
    else if (width != 0)
    begin
      widths.push_back(width);
      width <= 0;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic fail_out();
    errors++;
    print_verdict();
  endtask

  // hready and read data are taken at the rising edge, still showing the ending cycle
  task automatic ready_wait();
    int n = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50) fail_out();
      @(posedge core_clk);
    end
    rd = hrdata;
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    ready_wait();
    htrans <= 2'b00;
    hwdata <= d;
    ready_wait();
    check({31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic wait_close(input logic open);
    int n = 0;
    while ((channelClose === 16'h0000) !== open)
    begin
      n++;
      if (n > 3000) fail_out();
      @(posedge core_clk);
    end
  endtask

  task automatic pulse_ext();
    extEvent <= 1'b1;
    repeat (4) @(posedge core_clk);
    extEvent <= 1'b0;
  endtask

  // one scan; mode 0 handshake, 1 bus trigger, 2 external event
  task automatic scan(input logic [31:0] ctrl, input logic [31:0] len, input int mode);
    int n = 0;
    bus(OFF_CTRL, 1'b1, ctrl);
    bus(OFF_LIST_LEN, 1'b1, len);
    bus(OFF_OPER, 1'b0, 32'h0000_0000);
    closeLog.delete();
    doneLog.delete();
    widths.delete();
    bus(OFF_CMD, 1'b1, 32'h0000_0001);
    wait_close(1'b0);
    repeat (12) @(posedge core_clk);
    check({30'h0, analogBusRoute, treeARoute}, {30'h0, ctrl[4], ctrl[4]});
    if (mode == 0 && !eager)
    begin
      pulse_ext();
      bus(OFF_CMD, 1'b1, 32'h0000_0002);
      check({16'h0000, channelClose}, 32'h0000_0020);
    end
    while (mode != 0 && channelClose !== 16'h0000 && n < 8)
    begin
      n++;
      if (mode == 1) bus(OFF_CMD, 1'b1, 32'h0000_0002);
      else pulse_ext();
      repeat (30) @(posedge core_clk);
    end
    wait_close(1'b1);
    repeat (4) @(posedge core_clk);
    check(32'(closeLog.size()), len);
    foreach (closeLog[i]) check({16'h0, closeLog[i]}, {16'h0, 16'h0001 << chan[i]});
    check(32'(doneLog.size()), (mode == 0) ? len : 32'h0);
    foreach (doneLog[i]) check({16'h0, doneLog[i]}, {16'h0, 16'h0001 << chan[i]});
    foreach (widths[i]) check(widths[i], STROBE_CYC);
  endtask

  // reset, register table, then the scans and status checks
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    check({11'h0, channelDone, analogBusRoute, treeARoute, serviceRequest, irq, channelClose},
      32'h0000_0000);
    bus(OFF_CTRL, 1'b0, 32'h0000_0000);
    check(rd, CTRL_RESET);
    foreach (rows[i])
    begin
      bus(rows[i].a, 1'b1, rows[i].d);
      bus(rows[i].a, 1'b0, 32'h0000_0000);
      check(rd, rows[i].e);
    end
    for (int i = 0; i < 3; i++)
      bus(OFF_LIST_BASE + 8'(4 * i), 1'b1, {28'h0, chan[i]});
    scan(32'h0000_0114, 32'h0000_0003, 0);
    check({30'h0, serviceRequest, irq}, 32'h0000_0003);
    bus(OFF_STB, 1'b0, 32'h0000_0000);
    check(rd & 32'h0000_00c0, 32'h0000_00c0);
    bus(OFF_OPER, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0100);
    bus(OFF_OPER, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    eager <= 1'b1;
    lag <= 8'h00;
    scan(32'h0000_0114, 32'h0000_0003, 0);
    eager <= 1'b0;
    lag <= 8'h28;
    scan(32'h0000_0221, 32'h0000_0002, 1);
    scan(32'h0000_0103, 32'h0000_0002, 2);
    check({31'h0, serviceRequest}, 32'h0000_0001);
    bus(OFF_CMD, 1'b1, 32'h0000_0004);
    bus(OFF_OPER, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    bus(OFF_STB, 1'b0, 32'h0000_0000);
    check(rd & 32'h0000_00c0, 32'h0000_0000);
    check({30'h0, serviceRequest, irq}, 32'h0000_0000);
    // hold source by trigger command, then the free-running source
    scan(32'h0000_0102, 32'h0000_0002, 1);
    scan(32'h0000_0100, 32'h0000_0003, 2);
    // abort in mid-settle opens the channel and returns to idle
    bus(OFF_CTRL, 1'b1, 32'h0000_0102);
    bus(OFF_CMD, 1'b1, 32'h0000_0001);
    wait_close(1'b0);
    bus(OFF_CMD, 1'b1, 32'h0000_0008);
    bus(OFF_STATE, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check({16'h0000, channelClose}, 32'h0000_0000);
    // reset in mid-scan: outputs drop, control word back to its reset value
    bus(OFF_CMD, 1'b1, 32'h0000_0001);
    wait_close(1'b0);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    check({11'h0, channelDone, analogBusRoute, treeARoute, serviceRequest, irq, channelClose},
      32'h0000_0000);
    bus(OFF_CTRL, 1'b0, 32'h0000_0000);
    check(rd, CTRL_RESET);
    print_verdict();
  end
endmodule // scan_handshake_sequencer_test
`default_nettype wire
